// file: rcf_reset_cause.sv
// reset cause flags, reset sequencing and stabilisation wait, with an apb slave
// assumes watchdog and key reset requests come from logic on clk;
// the external reset pin is asynchronous and active low
`timescale 1ns/1ns
`include "rcf_params.svh"

// Overview of operation
// - the watchdog flag sits at bit 2 and the key flag at bit 3 of register index FC6.
// - before the first external reset software must not rely on either flag's value.
// - an asserted external reset pin forces both flags to zero.
// - a watchdog overflow reset sets the watchdog flag and leaves the key flag alone.
// - a key return reset sets the key flag and leaves the watchdog flag alone.
// - the clear of one flag zeroes that flag only.
// - a set flag stays set until an external reset or its own clear.
// - the selectable variant waits 2^17 or 2^15 main clock periods after power-up or the release of a reset taken in standby.
// - the fixed variant waits 56 ceramic clock periods after power-up or the release of a reset taken in standby.
module rcf_reset_cause
#(
  parameter bit WAIT_OPTION = 1'b1,
  parameter bit WAIT_LONG = 1'b1,
  parameter rcf_pkg::rcf_cnt_t LONG_WAIT_CYC =
    `RCF_CNT_W'(`RCF_CYC(`RCF_LONG_PER, `RCF_FX_HZ)),
  parameter rcf_pkg::rcf_cnt_t SHORT_WAIT_CYC =
    `RCF_CNT_W'(`RCF_CYC(`RCF_SHORT_PER, `RCF_FX_HZ)),
  parameter rcf_pkg::rcf_cnt_t CER_WAIT_CYC =
    `RCF_CNT_W'(`RCF_CYC(`RCF_CER_PER, `RCF_FCC_HZ))
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // reset sources
  input wire logic extResetN,
  input wire logic wdogOverflow,
  input wire logic keyReturnInput,
  input wire logic inStandby,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // processor control and flags
  output logic cpuHold,
  output logic watchdogResetFlag,
  output logic keyResetFlag,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // external pin synchroniser and request gathering

  logic [2:0] extSync_q;
  logic [2:0] extSync_d;
  logic extLvl_q;
  logic extLvl_d;
  rcf_pkg::rcf_evt_s req;
  rcf_pkg::rcf_evt_s reqPrev_q;
  rcf_pkg::rcf_evt_s reqPrev_d;
  rcf_pkg::rcf_evt_s reqRise;
  logic anyReq;

  always_comb
  begin
    extSync_d = {extSync_q[1:0], extResetN};
    extLvl_d = extLvl_q;
    // level changes only when second and third stage agree
    if (extSync_q[1] == extSync_q[2])
    begin
      extLvl_d = extSync_q[2];
    end
    req.ext = ~extLvl_q;
    req.wdog = wdogOverflow;
    req.key = keyReturnInput;
    reqPrev_d = req;
    reqRise = req & ~reqPrev_q;
    anyReq = req.ext | req.wdog | req.key;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      extSync_q <= `RCF_SYNC_ZERO;
      extLvl_q <= 1'b0;
      reqPrev_q <= '0;
    end
    else
    begin
      extSync_q <= extSync_d;
      extLvl_q <= extLvl_d;
      reqPrev_q <= reqPrev_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  rcf_pkg::rcf_apb_req_s apbReq;
  logic setupPhase;
  logic accessWr;
  logic hitFlags;
  logic hitStat;
  logic hitMask;
  logic hitState;
  logic hitAny;

  always_comb
  begin
    apbReq.paddr = paddr;
    apbReq.pwrite = pwrite;
    apbReq.pwdata = pwdata;
    setupPhase = psel & ~penable;
    accessWr = psel & penable & pready & apbReq.pwrite;
    hitFlags = 1'b0;
    hitStat = 1'b0;
    hitMask = 1'b0;
    hitState = 1'b0;
    if (apbReq.paddr == `RCF_ADDR(`RCF_IDX_FLAGS))
    begin
      hitFlags = 1'b1;
    end
    else if (apbReq.paddr == `RCF_ADDR(`RCF_IDX_STAT))
    begin
      hitStat = 1'b1;
    end
    else if (apbReq.paddr == `RCF_ADDR(`RCF_IDX_MASK))
    begin
      hitMask = 1'b1;
    end
    else if (apbReq.paddr == `RCF_ADDR(`RCF_IDX_STATE))
    begin
      hitState = 1'b1;
    end
    hitAny = hitFlags | hitStat | hitMask | hitState;
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset cause flags

  logic wdogFlag_q;
  logic wdogFlag_d;
  logic keyFlag_q;
  logic keyFlag_d;
  logic clrWdog;
  logic clrKey;

  always_comb
  begin
    clrWdog = accessWr & hitFlags & apbReq.pwdata[`RCF_WDOG_BIT];
    clrKey = accessWr & hitFlags & apbReq.pwdata[`RCF_KEY_BIT];
    wdogFlag_d = wdogFlag_q;
    keyFlag_d = keyFlag_q;
    // own clear touches only its own flag; a set in the same cycle wins
    if (clrWdog)
    begin
      wdogFlag_d = 1'b0;
    end
    if (clrKey)
    begin
      keyFlag_d = 1'b0;
    end
    if (req.wdog)
    begin
      wdogFlag_d = 1'b1;
    end
    if (req.key)
    begin
      keyFlag_d = 1'b1;
    end
    // external reset overrides everything
    if (req.ext)
    begin
      wdogFlag_d = 1'b0;
      keyFlag_d = 1'b0;
    end
  end

  // power-up value carries no meaning for software
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wdogFlag_q <= 1'b0;
      keyFlag_q <= 1'b0;
    end
    else
    begin
      wdogFlag_q <= wdogFlag_d;
      keyFlag_q <= keyFlag_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset sequencer and stabilisation wait

  rcf_pkg::rcf_state_e state_q;
  rcf_pkg::rcf_state_e state_d;
  logic fromStandby_q;
  logic fromStandby_d;
  logic hold_q;
  logic hold_d;
  logic waitStart;
  logic waitAbort;
  logic waitBusy;
  logic waitDone;
  rcf_pkg::rcf_cnt_t waitCount;

  always_comb
  begin
    // wait length fixed at build time by the variant
    if (WAIT_OPTION)
    begin
      waitCount = WAIT_LONG ? LONG_WAIT_CYC : SHORT_WAIT_CYC;
    end
    else
    begin
      waitCount = CER_WAIT_CYC;
    end
  end

  always_comb
  begin
    state_d = state_q;
    fromStandby_d = fromStandby_q;
    waitStart = 1'b0;
    waitAbort = 1'b0;
    case (state_q)
      rcf_pkg::ST_HOLD:
      begin
        if (!anyReq)
        begin
          if (fromStandby_q)
          begin
            state_d = rcf_pkg::ST_WAIT;
            waitStart = 1'b1;
          end
          else
          begin
            state_d = rcf_pkg::ST_RUN;
          end
        end
      end
      rcf_pkg::ST_WAIT:
      begin
        if (anyReq)
        begin
          state_d = rcf_pkg::ST_HOLD;
          waitAbort = 1'b1;
        end
        else if (waitDone)
        begin
          state_d = rcf_pkg::ST_RUN;
          fromStandby_d = 1'b0;
        end
      end
      rcf_pkg::ST_RUN:
      begin
        if (anyReq)
        begin
          state_d = rcf_pkg::ST_HOLD;
          fromStandby_d = inStandby;
        end
      end
      default:
      begin
        state_d = rcf_pkg::ST_HOLD;
      end
    endcase
    hold_d = (state_d != rcf_pkg::ST_RUN);
  end

  // power-up counts as a release from standby, so it waits too
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= rcf_pkg::ST_HOLD;
      fromStandby_q <= 1'b1;
      hold_q <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      fromStandby_q <= fromStandby_d;
      hold_q <= hold_d;
    end
  end

  rcf_wait_counter u_wait
  (
    .clk(clk),
    .rst(rst),
    .start(waitStart),
    .abort(waitAbort),
    .loadCount(waitCount),
    .busy(waitBusy),
    .done(waitDone)
  );

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status and mask

  logic [`RCF_EV_W-1:0] stat_q;
  logic [`RCF_EV_W-1:0] stat_d;
  logic [`RCF_EV_W-1:0] mask_q;
  logic [`RCF_EV_W-1:0] mask_d;
  logic [`RCF_EV_W-1:0] evSet;
  logic irq_q;
  logic irq_d;

  always_comb
  begin
    evSet = `RCF_EV_ZERO;
    evSet[`RCF_EV_WDOG] = reqRise.wdog;
    evSet[`RCF_EV_KEY] = reqRise.key;
    evSet[`RCF_EV_EXT] = reqRise.ext;
    evSet[`RCF_EV_WAIT] = waitDone;
    stat_d = stat_q;
    mask_d = mask_q;
    if (accessWr & hitStat)
    begin
      stat_d = stat_q & ~apbReq.pwdata[`RCF_EV_W-1:0];
    end
    // new events win over a clear in the same cycle
    stat_d = stat_d | evSet;
    if (accessWr & hitMask)
    begin
      mask_d = apbReq.pwdata[`RCF_EV_W-1:0];
    end
    irq_d = |(stat_d & mask_d);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      stat_q <= `RCF_EV_ZERO;
      mask_q <= `RCF_EV_ZERO;
      irq_q <= 1'b0;
    end
    else
    begin
      stat_q <= stat_d;
      mask_q <= mask_d;
      irq_q <= irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb read data and answer

  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;

  always_comb
  begin
    prdata_d = prdata_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    // answer in the cycle after setup, zero wait states
    if (setupPhase)
    begin
      pready_d = 1'b1;
      pslverr_d = ~hitAny;
      prdata_d = `RCF_ZERO32;
      if (!apbReq.pwrite)
      begin
        if (hitFlags)
        begin
          prdata_d[`RCF_WDOG_BIT] = wdogFlag_q;
          prdata_d[`RCF_KEY_BIT] = keyFlag_q;
        end
        else if (hitStat)
        begin
          prdata_d[`RCF_EV_W-1:0] = stat_q;
        end
        else if (hitMask)
        begin
          prdata_d[`RCF_EV_W-1:0] = mask_q;
        end
        else if (hitState)
        begin
          prdata_d[`RCF_ST_HOLD] = hold_q;
          prdata_d[`RCF_ST_BUSY] = waitBusy;
          prdata_d[`RCF_ST_OPT] = WAIT_OPTION;
          prdata_d[`RCF_ST_LONG] = WAIT_LONG;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      prdata_q <= `RCF_ZERO32;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign cpuHold = hold_q;
  assign watchdogResetFlag = wdogFlag_q;
  assign keyResetFlag = keyFlag_q;
  assign irq = irq_q;

endmodule

// file: rcf_params.svh
// constants for the reset cause flag block: offsets, bit positions, wait figures
// assumes a 50 MHz system clock and an APB bus with 16-bit byte addresses
`ifndef RCF_PARAMS_SVH
`define RCF_PARAMS_SVH

// register indexes; byte address is four times the index
`define RCF_IDX_FLAGS 12'hfc6
`define RCF_IDX_STAT 12'hfc0
`define RCF_IDX_MASK 12'hfc1
`define RCF_IDX_STATE 12'hfc2
`define RCF_ADDR(idx) ({2'b00, idx, 2'b00})

// flag positions in the reset cause register
`define RCF_WDOG_BIT 2
`define RCF_KEY_BIT 3

// event positions in the status and mask registers
`define RCF_EV_WDOG 0
`define RCF_EV_KEY 1
`define RCF_EV_EXT 2
`define RCF_EV_WAIT 3
`define RCF_EV_W 4

// state register bit positions
`define RCF_ST_HOLD 0
`define RCF_ST_BUSY 1
`define RCF_ST_OPT 2
`define RCF_ST_LONG 3

// reset values
`define RCF_ZERO32 32'h0000_0000
`define RCF_EV_ZERO 4'h0
`define RCF_SYNC_ZERO 3'h0

// timing: periods of the source clock and its rate, in Hz
`define RCF_CLK_HZ 64'h02fa_f080
`define RCF_FX_HZ 64'h005b_8d80
`define RCF_FCC_HZ 64'h000f_4240
`define RCF_LONG_PER 64'h0002_0000
`define RCF_SHORT_PER 64'h0000_8000
`define RCF_CER_PER 64'h0000_0038
`define RCF_CYC(per, hz) ((per * `RCF_CLK_HZ + hz - 64'h0000_0001) / hz)

`define RCF_CNT_W 21
`define RCF_CNT_ONE 21'h00_0001
`define RCF_CNT_ZERO 21'h00_0000

`endif

// file: rcf_pkg.sv
// types shared by the reset cause flag block
// assumes rcf_params.svh supplies the counter width
`include "rcf_params.svh"

package rcf_pkg;

  typedef logic [`RCF_CNT_W-1:0] rcf_cnt_t;

  typedef enum logic [1:0] {
    ST_HOLD,
    ST_WAIT,
    ST_RUN
  } rcf_state_e;

  // reset requests from the three sources
  typedef struct packed {
    logic ext;
    logic key;
    logic wdog;
  } rcf_evt_s;

  // apb request as seen by the slave
  typedef struct packed {
    logic [15:0] paddr;
    logic pwrite;
    logic [31:0] pwdata;
  } rcf_apb_req_s;

endpackage

// file: rcf_wait_counter.sv
// oscillation stabilisation wait counter
// assumes start and abort are single-cycle pulses from the same clock
`timescale 1ns/1ns
`include "rcf_params.svh"

module rcf_wait_counter
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic start,
  input wire logic abort,
  input wire rcf_pkg::rcf_cnt_t loadCount,
  // status
  output logic busy,
  output logic done
);

  rcf_pkg::rcf_cnt_t count_q;
  rcf_pkg::rcf_cnt_t count_d;
  logic busy_q;
  logic busy_d;
  logic done_q;
  logic done_d;

  always_comb
  begin
    count_d = count_q;
    busy_d = busy_q;
    done_d = 1'b0;
    if (abort)
    begin
      busy_d = 1'b0;
      count_d = `RCF_CNT_ZERO;
    end
    else if (start)
    begin
      busy_d = 1'b1;
      count_d = loadCount;
    end
    else if (busy_q)
    begin
      // terminal count ends the wait
      if (count_q <= `RCF_CNT_ONE)
      begin
        busy_d = 1'b0;
        done_d = 1'b1;
        count_d = `RCF_CNT_ZERO;
      end
      else
      begin
        count_d = count_q - `RCF_CNT_ONE;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      count_q <= `RCF_CNT_ZERO;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign busy = busy_q;
  assign done = done_q;

endmodule

// file: rcf_reset_cause_sva.sv
// checker for the reset cause block: flag sets, clears, holds, hold of the processor
// assumes one clock, rst active high, flag writes take effect with pready high
`timescale 1ns/1ns
`include "rcf_params.svh"

module rcf_reset_cause_sva
#(
  parameter rcf_pkg::rcf_cnt_t WAIT_CYC = 21'h00_0014
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // reset sources
  input wire logic extResetN,
  input wire logic wdogOverflow,
  input wire logic keyReturnInput,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  // watched outputs
  input wire logic cpuHold,
  input wire logic watchdogResetFlag,
  input wire logic keyResetFlag
);
  logic wrFlg, clrWd, clrKey, boot_q, boot_d;
  logic [31:0] up_q, up_d;

  default clocking dc @(posedge clk);
  endclocking
  default disable iff (rst);

  assign wrFlg = psel && penable && pready && pwrite && paddr == `RCF_ADDR(`RCF_IDX_FLAGS);
  assign clrWd = wrFlg && pwdata[`RCF_WDOG_BIT];
  assign clrKey = wrFlg && pwdata[`RCF_KEY_BIT];

  ////////////////////////////////////////////////////////////////
  // cycles since reset release, until the first run
  always_comb
  begin
    up_d = up_q + 32'h0000_0001;
    boot_d = boot_q && cpuHold;
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      up_q <= 32'h0000_0000;
      boot_q <= 1'b1;
    end
    else
    begin
      up_q <= up_d;
      boot_q <= boot_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  wd_flag_set_a: assert property (extResetN [*6] ##0 wdogOverflow |-> ##[1:2] watchdogResetFlag)
    else $error("watchdog flag not set");
  key_flag_set_a: assert property (extResetN [*6] ##0 keyReturnInput |-> ##[1:2] keyResetFlag)
    else $error("key flag not set");
  ext_clear_a: assert property (!extResetN [*6] |=> !watchdogResetFlag && !keyResetFlag)
    else $error("flags not cleared by pin");
  wd_flag_hold_a: assert property (extResetN [*6] ##0 (watchdogResetFlag && !clrWd &&
    !$past(clrWd)) |=> watchdogResetFlag)
    else $error("watchdog flag lost");
  key_flag_hold_a: assert property (extResetN [*6] ##0 (keyResetFlag && !clrKey &&
    !$past(clrKey)) |=> keyResetFlag)
    else $error("key flag lost");
  wd_flag_clr_a: assert property (clrWd && !wdogOverflow |=> ##[0:1] !watchdogResetFlag)
    else $error("watchdog flag not cleared");
  key_flag_clr_a: assert property (clrKey && !keyReturnInput |=> ##[0:1] !keyResetFlag)
    else $error("key flag not cleared");
  req_hold_a: assert property ((wdogOverflow || keyReturnInput) |=> cpuHold)
    else $error("processor not held");
  boot_wait_a: assert property (boot_q && $fell(cpuHold) |-> up_q >= WAIT_CYC &&
    up_q <= WAIT_CYC + 16)
    else $error("boot wait length wrong");
endmodule

bind rcf_reset_cause rcf_reset_cause_sva
  #(.WAIT_CYC(WAIT_OPTION ? (WAIT_LONG ? LONG_WAIT_CYC : SHORT_WAIT_CYC) : CER_WAIT_CYC))
  u_rcf_reset_cause_sva
(
  .clk(clk), .rst(rst), .extResetN(extResetN), .wdogOverflow(wdogOverflow),
  .keyReturnInput(keyReturnInput), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .paddr(paddr), .pwdata(pwdata), .cpuHold(cpuHold),
  .watchdogResetFlag(watchdogResetFlag), .keyResetFlag(keyResetFlag)
);

// file: rcf_src_model.sv
// model of the reset sources: pin, watchdog and key return requests
// assumes the caller runs fire from the bench's main thread
`timescale 1ns/1ns

module rcf_src_model
(
  // clock
  input wire logic clk,
  // requests toward the block
  output logic extResetN,
  output logic wdogOverflow,
  output logic keyReturnInput,
  output logic inStandby
);
  initial
  begin
    extResetN = 1'b1;
    wdogOverflow = 1'b0;
    keyReturnInput = 1'b0;
    inStandby = 1'b0;
  end

  // kind 0 watchdog, 1 key, 2 pin; released pin goes to its pull-up level
  task fire(input int kind, input int n, input logic stby);
    @(posedge clk);
    inStandby <= stby;
    wdogOverflow <= (kind == 0);
    keyReturnInput <= (kind == 1);
    extResetN <= (kind != 2);
    repeat (n) @(posedge clk);
    wdogOverflow <= 1'b0;
    keyReturnInput <= 1'b0;
    extResetN <= 1'b1;
    inStandby <= 1'b0;
  endtask
endmodule

// file: rcf_reset_cause_tb.sv
// testbench for the reset cause block: boot wait, flags, clears, interrupt, bad address
// assumes the source model drives the reset inputs
`timescale 1ns/1ns
`include "rcf_params.svh"

module rcf_reset_cause_tb;
  localparam int LONG = 20;
  localparam int CER = 5;
  localparam logic [15:0] A_FLG = `RCF_ADDR(`RCF_IDX_FLAGS);
  localparam logic [15:0] A_STAT = `RCF_ADDR(`RCF_IDX_STAT);
  localparam logic [15:0] A_MASK = `RCF_ADDR(`RCF_IDX_MASK);
  localparam logic [15:0] A_ST = `RCF_ADDR(`RCF_IDX_STATE);
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rdv;
  logic pready, pslverr, cpuHold, wdFlag, keyFlag, irq, erv;
  logic extResetN, wdogOverflow, keyReturnInput, inStandby, cerHold;
  int fail_count = 0;
  int n_compared = 0;
  int cyc, cerCyc;

  always #10 clk = ~clk;

  rcf_src_model u_rcf_src_model (.clk(clk), .extResetN(extResetN), .wdogOverflow(wdogOverflow),
    .keyReturnInput(keyReturnInput), .inStandby(inStandby));

  rcf_reset_cause #(.WAIT_OPTION(1'b1), .WAIT_LONG(1'b1), .LONG_WAIT_CYC(21'h00_0014),
    .SHORT_WAIT_CYC(21'h00_000a), .CER_WAIT_CYC(21'h00_0005)) u_rcf_reset_cause (.clk(clk),
    .rst(rst), .extResetN(extResetN), .wdogOverflow(wdogOverflow),
    .keyReturnInput(keyReturnInput), .inStandby(inStandby), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpuHold(cpuHold), .watchdogResetFlag(wdFlag),
    .keyResetFlag(keyFlag), .irq(irq));

  // fixed-wait variant on the same inputs
  rcf_reset_cause #(.WAIT_OPTION(1'b0), .WAIT_LONG(1'b0), .LONG_WAIT_CYC(21'h00_0014),
    .SHORT_WAIT_CYC(21'h00_000a), .CER_WAIT_CYC(21'h00_0005)) u_rcf_reset_cause_cer
    (.clk(clk), .rst(rst), .extResetN(extResetN), .wdogOverflow(wdogOverflow),
    .keyReturnInput(keyReturnInput), .inStandby(inStandby), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
    .cpuHold(cerHold), .watchdogResetFlag(), .keyResetFlag(), .irq());

  ////////////////////////////////////////////////////////////////
  task close_out;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task apb(input logic wr, input logic [15:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd(input logic [15:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, e, rdv);
  endtask

  // cycles from request release until the processor runs
  task run_wait;
    repeat (2) @(posedge clk);
    cyc = 2;
    while (cerHold !== 1'b0 && cyc < 500)
    begin
      @(posedge clk);
      cyc++;
    end
    cerCyc = cyc;
    while (cpuHold !== 1'b0 && cyc < 500)
    begin
      @(posedge clk);
      cyc++;
    end
    chk("cpu hold", 32'h0000_0000, {31'h0, cpuHold});
  endtask

  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    run_wait();
    chk("boot wait", 32'h0000_0001, 32'(cyc >= LONG && cyc <= LONG + 10));
    chk("fixed boot wait", 32'h0000_0001, 32'(cerCyc >= CER && cerCyc <= CER + 10));
    rd(A_FLG, 32'h0000_0000, "flags at boot");
    rd(A_ST, 32'h0000_000c, "state");
    rd(A_MASK, 32'h0000_0000, "mask reset");
    $display("boot test done");
    u_rcf_src_model.fire(0, 1, 1'b0);
    run_wait();
    chk("run hold", 32'h0000_0001, 32'(cyc <= 5));
    rd(A_FLG, 32'h0000_0004, "wd flag");
    u_rcf_src_model.fire(1, 1, 1'b1);
    run_wait();
    chk("standby wait", 32'h0000_0001, 32'(cyc >= LONG && cyc <= LONG + 8));
    chk("fixed standby wait", 32'h0000_0001, 32'(cerCyc >= CER && cerCyc <= CER + 8));
    rd(A_FLG, 32'h0000_000c, "both flags");
    chk("flag pins", 32'h0000_0003, {30'h0, keyFlag, wdFlag});
    apb(1'b1, A_FLG, 32'h0000_0004);
    rd(A_FLG, 32'h0000_0008, "wd cleared");
    apb(1'b1, A_FLG, 32'h0000_0008);
    rd(A_FLG, 32'h0000_0000, "key cleared");
    $display("flag test done");
    apb(1'b1, A_STAT, 32'h0000_000f);
    apb(1'b1, A_MASK, 32'h0000_0002);
    u_rcf_src_model.fire(0, 1, 1'b0);
    run_wait();
    chk("irq masked", 32'h0000_0000, {31'h0, irq});
    u_rcf_src_model.fire(1, 1, 1'b0);
    run_wait();
    chk("irq raised", 32'h0000_0001, {31'h0, irq});
    rd(A_STAT, 32'h0000_0003, "status");
    apb(1'b1, A_STAT, 32'h0000_0003);
    repeat (3) @(posedge clk);
    chk("irq cleared", 32'h0000_0000, {31'h0, irq});
    $display("interrupt test done");
    u_rcf_src_model.fire(2, 6, 1'b0);
    run_wait();
    rd(A_FLG, 32'h0000_0000, "pin clear");
    rd(16'h0100, 32'h0000_0000, "unmapped data");
    chk("unmapped err", 32'h0000_0001, {31'h0, erv});
    $display("pin and address test done");
    close_out();
  end

  initial
  begin
    #(20 * 5000);
    fail_count++;
    $display("[ERR] run end expected finish seen timeout");
    close_out();
  end
endmodule
